// file: hdl/oamlrs_pkg.sv
package oamlrs_pkg;
  // ----------------------------------------------------------------
  // bus geometry and register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_SETUP = 8'h44;
  localparam logic [7:0] IDX_TO_CNT = 8'h47;
  localparam logic [7:0] IDX_GOOD_CNT = 8'h48;
  localparam logic [7:0] IDX_ADD_STAT = 8'h49;
  localparam logic [7:0] IDX_RCMD1 = 8'h4a;
  localparam logic [7:0] IDX_CTRL = 8'h60;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h61;
  localparam logic [7:0] IDX_IRQ_EN = 8'h62;
  localparam logic [7:0] IDX_IRQ_CLR = 8'h63;
  // ----------------------------------------------------------------
  // reset values and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] SETUP_RST = 8'h07;
  localparam logic [7:0] SETUP_CLEAR_VAL = 8'h00;
  localparam logic [7:0] RCMD1_RST = 8'h22;
  localparam logic [7:0] RCMD1_RO_MASK = 8'h30;
  localparam logic [1:0] MODEL_RST = 2'h0;
  localparam logic [1:0] MODEL_15KM = 2'h0;
  localparam logic [1:0] MODEL_40KM = 2'h1;
  localparam logic CTRL_CO_RST = 1'b0;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam int CNT_W = 8;
  localparam int STAT_HARD_LO = 6;
  localparam int STAT_MODEL_LO = 4;
  localparam int STAT_STOP = 3;
  localparam int STAT_LOOP_DUR = 2;
  localparam int STAT_REPLY = 1;
  localparam int STAT_LINK = 0;
  localparam int CTRL_CO_BIT = 0;
  localparam int RCMD_ACK_BIT = 6;
  localparam int RCMD_OPC_LO = 2;
  localparam logic [2:0] CMD_READ_REQ = 3'h1;
  localparam logic [2:0] CMD_READ_ACK = 3'h5;
  localparam int N_EVT = 5;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic reply_to;
    logic loop_dur;
    logic stop_ind;
    logic good_pkt;
    logic timeout_pkt;
  } oamlrs_evt_type;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } oamlrs_apb_req_type;
endpackage

// file: hdl/oamlrs_sat_counter.sv
`timescale 1ns/100ps
module oamlrs_sat_counter #(
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic inc,
  input wire logic clr,
  output logic [WIDTH-1:0] count
);
  import oamlrs_pkg::*;
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } oamlrs_cnt_state_type;
  oamlrs_cnt_state_type state_reg;
  oamlrs_cnt_state_type state_next;

  always_comb begin
    state_next = state_reg;
    if (clr) begin
      // an event in the clearing cycle is kept
      state_next.cnt = inc ? WIDTH'(1) : '0;
    end else if (inc && (state_reg.cnt != {WIDTH{1'b1}})) begin
      state_next.cnt = state_reg.cnt + WIDTH'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign count = state_reg.cnt;
endmodule

// file: hdl/oamlrs_irq.sv
`timescale 1ns/100ps
module oamlrs_irq #(
  parameter int N = 5
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [N-1:0] evt,
  input wire logic en_we,
  input wire logic clr_we,
  input wire logic [N-1:0] wdata,
  output logic [N-1:0] status,
  output logic [N-1:0] enable,
  output logic irq
);
  import oamlrs_pkg::*;
  typedef struct packed {
    logic [N-1:0] status;
    logic [N-1:0] enable;
  } oamlrs_irq_state_type;
  oamlrs_irq_state_type state_reg;
  oamlrs_irq_state_type state_next;

  always_comb begin
    state_next = state_reg;
    if (en_we) begin
      state_next.enable = wdata;
    end
    // write one to clear, a new event wins
    state_next.status = (state_reg.status & ~(clr_we ? wdata : '0)) | evt;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign status = state_reg.status;
  assign enable = state_reg.enable;
  assign irq = |(state_reg.status & state_reg.enable);
endmodule

// file: hdl/oamlrs_top.sv
// Our own choice: the APB register port.
`timescale 1ns/100ps
// Behaviour
// - 8-bit read-only count of timed-out loop-back packets in central-office mode, 0 to 255
// - separate 8-bit read-only count of good returned loop-back packets in central-office mode
// - writing zero to the loop-back setup register clears both counts
// - status bits 7:6 are a fixed read-only hardware version
// - stop-indication flag, bit 3, set on stop frame, clears on read
// - loop-duration flag, bit 2, set on loop timer expiry, clears on read
// - reply timeout flag, bit 1, set on reply wait expiry, clears on read
// - status bit 0 reads one while port 1 link is down
// - bits 6,3,2 of remote command: 001 read request, 101 read ack
module oamlrs_top #(
  // arbitrary value, not tied to any real part
  parameter logic [1:0] HARD_VERSION = 2'h2
) (
  input wire logic clock,
  input wire logic rst_n,
  input oamlrs_pkg::oamlrs_apb_req_type apb_req,
  output logic [oamlrs_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input oamlrs_pkg::oamlrs_evt_type evt,
  input wire logic port1_link_down,
  output logic cmd_read_request,
  output logic cmd_read_ack,
  output logic irq
);
  import oamlrs_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] setup;
    logic [1:0] model;
    logic stop_indication_flag;
    logic loop_duration_flag;
    logic reply_timeout_flag;
    logic [7:0] rcmd1;
    logic co_mode;
    logic [DATA_W-1:0] rdata;
  } oamlrs_top_state_type;
  oamlrs_top_state_type state_reg;
  oamlrs_top_state_type state_next;

  logic [7:0] idx;
  logic setup_ph;
  logic access_ph;
  logic wr;
  logic rd;
  logic mapped;
  logic cnt_clr;
  logic to_inc;
  logic good_inc;
  logic [CNT_W-1:0] to_count;
  logic [CNT_W-1:0] good_count;
  logic [N_EVT-1:0] irq_status;
  logic [N_EVT-1:0] irq_enable;
  logic [7:0] add_status;
  logic [2:0] cmd_sel;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign idx = apb_req.paddr[ADDR_W-1:2];
  assign setup_ph = apb_req.psel && !apb_req.penable;
  assign access_ph = apb_req.psel && apb_req.penable;
  assign wr = access_ph && apb_req.pwrite;
  assign rd = access_ph && !apb_req.pwrite;

  always_comb begin
    case (idx)
      IDX_SETUP, IDX_TO_CNT, IDX_GOOD_CNT, IDX_ADD_STAT, IDX_RCMD1,
      IDX_CTRL, IDX_IRQ_STAT, IDX_IRQ_EN, IDX_IRQ_CLR: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = access_ph && !mapped;
  assign prdata = state_reg.rdata;

  // ----------------------------------------------------------------
  // result counters
  // ----------------------------------------------------------------
  assign cnt_clr = wr && (idx == IDX_SETUP) && (apb_req.pwdata[7:0] == SETUP_CLEAR_VAL);
  assign to_inc = state_reg.co_mode && evt.timeout_pkt;
  assign good_inc = state_reg.co_mode && evt.good_pkt;

  oamlrs_sat_counter #(
    .WIDTH(CNT_W)
  ) u_to_cnt (
    .clock(clock),
    .rst_n(rst_n),
    .inc(to_inc),
    .clr(cnt_clr),
    .count(to_count)
  );

  oamlrs_sat_counter #(
    .WIDTH(CNT_W)
  ) u_good_cnt (
    .clock(clock),
    .rst_n(rst_n),
    .inc(good_inc),
    .clr(cnt_clr),
    .count(good_count)
  );

  // ----------------------------------------------------------------
  // interrupt status, enable and clear
  // ----------------------------------------------------------------
  oamlrs_irq #(
    .N(N_EVT)
  ) u_irq (
    .clock(clock),
    .rst_n(rst_n),
    .evt(evt),
    .en_we(wr && (idx == IDX_IRQ_EN)),
    .clr_we(wr && (idx == IDX_IRQ_CLR)),
    .wdata(apb_req.pwdata[N_EVT-1:0]),
    .status(irq_status),
    .enable(irq_enable),
    .irq(irq)
  );

  // ----------------------------------------------------------------
  // additional status and command decode
  // ----------------------------------------------------------------
  always_comb begin
    add_status = '0;
    add_status[STAT_HARD_LO +: 2] = HARD_VERSION;
    add_status[STAT_MODEL_LO +: 2] = state_reg.model;
    add_status[STAT_STOP] = state_reg.stop_indication_flag;
    add_status[STAT_LOOP_DUR] = state_reg.loop_duration_flag;
    add_status[STAT_REPLY] = state_reg.reply_timeout_flag;
    add_status[STAT_LINK] = port1_link_down;
  end

  assign cmd_sel = {state_reg.rcmd1[RCMD_ACK_BIT], state_reg.rcmd1[RCMD_OPC_LO +: 2]};
  assign cmd_read_request = (cmd_sel == CMD_READ_REQ);
  assign cmd_read_ack = (cmd_sel == CMD_READ_ACK);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    // read data is captured in the setup cycle
    if (setup_ph && !apb_req.pwrite) begin
      state_next.rdata = '0;
      case (idx)
        IDX_SETUP: state_next.rdata[7:0] = state_reg.setup;
        IDX_TO_CNT: state_next.rdata[7:0] = to_count;
        IDX_GOOD_CNT: state_next.rdata[7:0] = good_count;
        IDX_ADD_STAT: state_next.rdata[7:0] = add_status;
        IDX_RCMD1: state_next.rdata[7:0] = state_reg.rcmd1;
        IDX_CTRL: state_next.rdata[CTRL_CO_BIT] = state_reg.co_mode;
        IDX_IRQ_STAT: state_next.rdata[N_EVT-1:0] = irq_status;
        IDX_IRQ_EN: state_next.rdata[N_EVT-1:0] = irq_enable;
        default: state_next.rdata = '0;
      endcase
    end
    if (wr) begin
      case (idx)
        IDX_SETUP: state_next.setup = apb_req.pwdata[7:0];
        IDX_ADD_STAT: state_next.model = apb_req.pwdata[STAT_MODEL_LO +: 2];
        IDX_RCMD1: begin
          if (state_reg.co_mode) begin
            state_next.rcmd1 = (apb_req.pwdata[7:0] & ~RCMD1_RO_MASK) | (RCMD1_RST & RCMD1_RO_MASK);
          end
        end
        IDX_CTRL: state_next.co_mode = apb_req.pwdata[CTRL_CO_BIT];
        default: state_next.setup = state_reg.setup;
      endcase
    end
    // clear on read only what the read reported; a new event wins
    if (rd && (idx == IDX_ADD_STAT)) begin
      state_next.stop_indication_flag = state_reg.stop_indication_flag && !state_reg.rdata[STAT_STOP];
      state_next.loop_duration_flag = state_reg.loop_duration_flag && !state_reg.rdata[STAT_LOOP_DUR];
      state_next.reply_timeout_flag = state_reg.reply_timeout_flag && !state_reg.rdata[STAT_REPLY];
    end
    if (evt.stop_ind) begin
      state_next.stop_indication_flag = 1'b1;
    end
    if (evt.loop_dur) begin
      state_next.loop_duration_flag = 1'b1;
    end
    if (evt.reply_to) begin
      state_next.reply_timeout_flag = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg.setup <= SETUP_RST;
      state_reg.model <= MODEL_RST;
      state_reg.stop_indication_flag <= 1'b0;
      state_reg.loop_duration_flag <= 1'b0;
      state_reg.reply_timeout_flag <= 1'b0;
      state_reg.rcmd1 <= RCMD1_RST;
      state_reg.co_mode <= CTRL_CO_RST;
      state_reg.rdata <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence read_setup_s(logic [7:0] i);
    setup_ph && !apb_req.pwrite && (idx == i);
  endsequence

  sequence read_access_s(logic [7:0] i);
    rd && (idx == i);
  endsequence

  sequence write_s(logic [7:0] i);
    wr && (idx == i);
  endsequence

  sequence status_read_s;
    read_setup_s(IDX_ADD_STAT) ##1 read_access_s(IDX_ADD_STAT);
  endsequence

  timeout_count_inc_a: assert property (to_inc && !cnt_clr && (to_count != CNT_MAX)
    |=> to_count == $past(to_count) + 8'h01)
    else $error("timeout count did not advance");

  timeout_count_ro_a: assert property (write_s(IDX_TO_CNT) ##0 !to_inc
    |=> $stable(to_count))
    else $error("timeout count changed by a write");

  good_count_inc_a: assert property (good_inc && !cnt_clr && (good_count != CNT_MAX)
    |=> good_count == $past(good_count) + 8'h01)
    else $error("good count did not advance");

  good_count_ro_a: assert property (write_s(IDX_GOOD_CNT) ##0 !good_inc
    |=> $stable(good_count))
    else $error("good count changed by a write");

  setup_clears_counts_a: assert property (cnt_clr && !evt.timeout_pkt && !evt.good_pkt
    |=> (to_count == 8'h00) && (good_count == 8'h00))
    else $error("setup write of zero did not clear counts");

  clear_keeps_event_a: assert property (cnt_clr && to_inc
    |=> to_count == 8'h01)
    else $error("event lost in clearing cycle");

  setup_write_a: assert property (write_s(IDX_SETUP)
    |=> state_reg.setup == $past(apb_req.pwdata[7:0]))
    else $error("setup register not written");

  cpe_counts_hold_a: assert property (!state_reg.co_mode && !cnt_clr
    |=> $stable(to_count) && $stable(good_count))
    else $error("count moved outside central-office mode");

  model_write_a: assert property (write_s(IDX_ADD_STAT)
    |=> state_reg.model == $past(apb_req.pwdata[5:4]))
    else $error("model field not written");

  hard_version_read_a: assert property (status_read_s |-> prdata[7:6] == HARD_VERSION)
    else $error("hard version field wrong");

  stop_flag_set_a: assert property (evt.stop_ind |=> state_reg.stop_indication_flag)
    else $error("stop indication flag not set");

  stop_self_clear_a: assert property (status_read_s ##0 (prdata[3] && !evt.stop_ind)
    |=> !state_reg.stop_indication_flag)
    else $error("stop indication flag not cleared by read");

  loop_flag_set_a: assert property (evt.loop_dur |=> state_reg.loop_duration_flag)
    else $error("loop duration flag not set");

  loop_self_clear_a: assert property (status_read_s ##0 (prdata[2] && !evt.loop_dur)
    |=> !state_reg.loop_duration_flag)
    else $error("loop duration flag not cleared by read");

  reply_flag_set_a: assert property (evt.reply_to |=> state_reg.reply_timeout_flag)
    else $error("reply timeout flag not set");

  reply_self_clear_a: assert property (status_read_s ##0 (prdata[1] && !evt.reply_to)
    |=> !state_reg.reply_timeout_flag)
    else $error("reply timeout flag not cleared by read");

  link_down_read_a: assert property (status_read_s |-> prdata[0] == $past(port1_link_down))
    else $error("link down bit wrong");

  rcmd_cpe_hold_a: assert property (write_s(IDX_RCMD1) ##0 !state_reg.co_mode
    |=> $stable(state_reg.rcmd1))
    else $error("remote command written outside central-office mode");

  rcmd_ro_bits_a: assert property (state_reg.rcmd1[5:4] == RCMD1_RST[5:4])
    else $error("remote command read-only bits changed");

  cmd_decode_a: assert property (write_s(IDX_RCMD1) ##0 state_reg.co_mode
    |=> cmd_read_ack == ({$past(apb_req.pwdata[6]), $past(apb_req.pwdata[3:2])} == 3'h5))
    else $error("read acknowledge decode wrong");

  cmd_request_a: assert property (write_s(IDX_RCMD1) ##0 state_reg.co_mode
    |=> cmd_read_request == ({$past(apb_req.pwdata[6]), $past(apb_req.pwdata[3:2])} == 3'h1))
    else $error("read request decode wrong");

  count_saturate_a: assert property ((to_count == CNT_MAX) && !cnt_clr
    |=> to_count == CNT_MAX)
    else $error("timeout count wrapped");

  good_saturate_a: assert property ((good_count == CNT_MAX) && !cnt_clr
    |=> good_count == CNT_MAX)
    else $error("good count wrapped");

  ctrl_write_a: assert property (write_s(IDX_CTRL)
    |=> state_reg.co_mode == $past(apb_req.pwdata[0]))
    else $error("side select not written");

  irq_status_set_a: assert property (evt.good_pkt |=> irq_status[1])
    else $error("interrupt status not set");

  irq_enable_write_a: assert property (write_s(IDX_IRQ_EN)
    |=> irq_enable == $past(apb_req.pwdata[4:0]))
    else $error("interrupt enable not written");

  irq_clear_a: assert property (write_s(IDX_IRQ_CLR) ##0 (evt == '0)
    |=> (irq_status & $past(apb_req.pwdata[4:0])) == 5'h00)
    else $error("interrupt status not cleared");

  irq_raise_a: assert property (evt.stop_ind && irq_enable[2] && !wr
    |=> irq)
    else $error("interrupt not raised");

  unmapped_error_a: assert property (read_setup_s(8'hff) ##1 read_access_s(8'hff)
    |-> pslverr && (prdata == '0))
    else $error("unmapped read not refused");
endmodule

// file: testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
  import oamlrs_pkg::*;
  logic clock;
  logic rst_n;
  oamlrs_apb_req_type apb_req;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  oamlrs_evt_type evt;
  logic port1_link_down;
  logic cmd_read_request;
  logic cmd_read_ack;
  logic irq;
  int fail_count;
  int compares;
  logic [31:0] v;
  logic e;

  oamlrs_top dut (
    .clock(clock),
    .rst_n(rst_n),
    .apb_req(apb_req),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .evt(evt),
    .port1_link_down(port1_link_down),
    .cmd_read_request(cmd_read_request),
    .cmd_read_ack(cmd_read_ack),
    .irq(irq)
  );

  // ----------------------------------------------------------------
  // clock, reset, watchdog
  // ----------------------------------------------------------------
  initial clock = 1'b0;
  always #4 clock = ~clock;

  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr_en, input logic [9:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd_v, output logic err);
    @(posedge clock);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr_en, paddr: addr, pwdata: wd};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    // wait for ready; only the watchdog ends a hang
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd_v = prdata;
    err = pslverr;
    apb_req <= '0;
  endtask

  task automatic wr(input logic [9:0] addr, input logic [31:0] d);
    logic [31:0] rv;
    logic re;
    apb(1'b1, addr, d, rv, re);
  endtask

  task automatic rd(input logic [9:0] addr, input logic [31:0] exp);
    logic [31:0] rv;
    logic re;
    apb(1'b0, addr, 32'h0, rv, re);
    chk(rv, exp);
    chk({31'h0, re}, 32'h0);
  endtask

  // back-to-back pulses, one per cycle
  task automatic pulse(input logic [4:0] m, input int n);
    repeat (n) begin
      @(posedge clock);
      evt <= oamlrs_evt_type'(m);
    end
    @(posedge clock);
    evt <= '0;
    @(negedge clock);
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    fail_count = 0;
    compares = 0;
    rst_n = 1'b0;
    apb_req = '0;
    evt = '0;
    port1_link_down = 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    rd(10'h110, 32'h07);
    rd(10'h128, 32'h22);
    rd(10'h11c, 32'h00);
    rd(10'h120, 32'h00);
    chk({30'h0, cmd_read_request, cmd_read_ack}, 32'h0);
    done("reset");
    pulse(5'h01, 2);
    rd(10'h11c, 32'h00);
    wr(10'h180, 32'h1);
    pulse(5'h01, 3);
    pulse(5'h02, 1);
    rd(10'h11c, 32'h03);
    rd(10'h120, 32'h01);
    wr(10'h11c, 32'h55);
    rd(10'h11c, 32'h03);
    done("counts");
    pulse(5'h01, 260);
    rd(10'h11c, 32'hff);
    wr(10'h110, 32'h05);
    rd(10'h11c, 32'hff);
    wr(10'h110, 32'h00);
    rd(10'h11c, 32'h00);
    rd(10'h120, 32'h00);
    done("saturate_clear");
    port1_link_down <= 1'b1;
    pulse(5'h1c, 1);
    rd(10'h124, 32'h8f);
    rd(10'h124, 32'h81);
    port1_link_down <= 1'b0;
    wr(10'h124, 32'h10);
    rd(10'h124, 32'h90);
    wr(10'h124, 32'h00);
    rd(10'h124, 32'h80);
    pulse(5'h08, 1);
    rd(10'h124, 32'h84);
    pulse(5'h10, 1);
    rd(10'h124, 32'h82);
    rd(10'h124, 32'h80);
    done("status");
    wr(10'h128, 32'h44);
    @(negedge clock);
    chk({30'h0, cmd_read_request, cmd_read_ack}, 32'h1);
    rd(10'h128, 32'h64);
    wr(10'h128, 32'h04);
    @(negedge clock);
    chk({30'h0, cmd_read_request, cmd_read_ack}, 32'h2);
    wr(10'h180, 32'h0);
    wr(10'h128, 32'h44);
    rd(10'h128, 32'h24);
    done("remote_cmd");
    wr(10'h18c, 32'h1f);
    wr(10'h188, 32'h04);
    @(negedge clock);
    chk({31'h0, irq}, 32'h0);
    pulse(5'h04, 1);
    chk({31'h0, irq}, 32'h1);
    pulse(5'h02, 1);
    rd(10'h184, 32'h06);
    wr(10'h18c, 32'h04);
    @(negedge clock);
    chk({31'h0, irq}, 32'h0);
    rd(10'h184, 32'h02);
    rd(10'h18c, 32'h00);
    done("irq");
    apb(1'b0, 10'h3fc, 32'h0, v, e);
    chk({31'h0, e}, 32'h1);
    chk(v, 32'h0);
    done("unmapped");
    stop_test();
  end
endmodule
